/* rtl/sfcfe_front_end.v */
// Behaviour
// - Clock idles low in mode 0, high in mode 3; both accepted.
// - Input sampled on rising clock edges, output changed on falling.
// - Chip select low opens a frame, rising chip select closes it.
// - Each frame starts with a command byte, then command-dependent bytes.
// - The first eight output bits are always the fast status byte.
// - Response data follows only after every required input byte.
// - Unknown command bytes cause no action.
// - Clocks and bits beyond the frame length are ignored.
// - Multi-byte fields travel most significant byte first.
// - 15h: three address bytes, dummy, returns word; seven bytes.
// - 16h: dummy only, returns next word after last access; four bytes.
// - 17h: address, two data, dummy; programs word; seven bytes.
// - 18h: two data, dummy; programs next address; four bytes.
// - 22: no input, returns status word; three bytes.
// - 1D: address, two data, dummy; writes configuration register.
// - 1E: address, dummy; returns configuration register word.
// - 1F: two data, dummy; forwarded as special-function command.
// - Bit 6 flags a frame closed before its inputs completed.
// - Bit 5 program busy, 4 erase busy, 3 device busy; 7 zero.
// - Bit 2 flags an attempt to raise a programmed bit.
// - Bit 1 flags a read of unavailable data.
// - Bit 0 flags a failed command and stays until cleared.
// - 1F with data 0040 clears command and invalid-data errors.
// - Sticky errors show one frame late; device busy clears one frame late.
`timescale 1ns/1ps
`default_nettype none
`include "sfcfe_consts.vh"

module sfcfe_front_end #(
    // Arbitrary value, not tied to any real part
    parameter [3:0] SILICON_REVISION_FIELD = 4'h5
) (
    input  wire        i_ref_clk,
    input  wire        i_rst_n,
    input  wire        i_cs_n,
    input  wire        i_sck,
    input  wire        i_si,
    output reg         o_so,
    output reg         o_so_oe,
    output reg  [23:0] o_rd_addr,
    output reg         o_rd_cfg,
    input  wire [15:0] i_rd_data,
    input  wire        i_rd_ok,
    output wire        o_req_valid,
    output wire [7:0]  o_req_cmd,
    output wire [23:0] o_req_addr,
    output wire [15:0] o_req_data,
    input  wire        i_req_ready,
    input  wire        i_read_busy,
    input  wire        i_write_busy,
    input  wire        i_erase_busy,
    input  wire        i_write_susp,
    input  wire        i_erase_susp,
    input  wire        i_pump_ready,
    input  wire        i_cmd_fail,
    input  wire        i_invalid_data,
    output reg  [7:0]  o_fast_status_byte,
    output reg  [15:0] o_device_state_word
);

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: a change counts once stages two and three agree
    reg [2:0] sck_p;
    reg [2:0] cs_p;
    reg [2:0] si_p;
    reg       sck_q;
    reg       cs_q;
    wire      sck_agree;
    wire      cs_agree;
    wire      sck_rise;
    wire      sck_fall;
    wire      cs_fall;
    wire      cs_rise;

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            sck_p <= 3'h0;
            cs_p  <= 3'h7;
            si_p  <= 3'h0;
            sck_q <= 1'b0;
            cs_q  <= 1'b1;
        end else begin
            sck_p <= {sck_p[1:0], i_sck};
            cs_p  <= {cs_p[1:0], i_cs_n};
            si_p  <= {si_p[1:0], i_si};
            if (sck_agree) begin
                sck_q <= sck_p[2];
            end
            if (cs_agree) begin
                cs_q <= cs_p[2];
            end
        end
    end

    assign sck_agree = (sck_p[1] == sck_p[2]);
    assign cs_agree  = (cs_p[1] == cs_p[2]);
    // Edges only, so the idle level (mode 0 or 3) never matters
    assign sck_rise  = sck_agree & sck_p[2] & ~sck_q;
    assign sck_fall  = sck_agree & ~sck_p[2] & sck_q;
    assign cs_fall   = cs_agree & ~cs_p[2] & cs_q;
    assign cs_rise   = cs_agree & cs_p[2] & ~cs_q;

////////////////////////////////////////////////////////////////////////////
// Command decode
    function [2:0] sfcfe_in_len;
        input [7:0] cmd;
        begin
            case (cmd)
                `SFCFE_CMD_RD:      sfcfe_in_len = `SFCFE_LEN_RD;
                `SFCFE_CMD_RD_AUTO: sfcfe_in_len = `SFCFE_LEN_RD_AUTO;
                `SFCFE_CMD_WR:      sfcfe_in_len = `SFCFE_LEN_WR;
                `SFCFE_CMD_WR_AUTO: sfcfe_in_len = `SFCFE_LEN_WR_AUTO;
                `SFCFE_CMD_ERASE:   sfcfe_in_len = `SFCFE_LEN_SEG;
                `SFCFE_CMD_VALID:   sfcfe_in_len = `SFCFE_LEN_SEG;
                `SFCFE_CMD_CFG_WR:  sfcfe_in_len = `SFCFE_LEN_CFG_WR;
                `SFCFE_CMD_CFG_RD:  sfcfe_in_len = `SFCFE_LEN_CFG_RD;
                `SFCFE_CMD_SPECIAL: sfcfe_in_len = `SFCFE_LEN_SPECIAL;
                `SFCFE_CMD_STATUS:  sfcfe_in_len = `SFCFE_LEN_STATUS;
                default:            sfcfe_in_len = `SFCFE_LEN_NONE;
            endcase
        end
    endfunction

    reg  [7:0]  cmd;
    reg  [23:0] addr;
    reg  [15:0] data;
    reg  [23:0] addr_ptr;
    wire        has_addr;
    wire        is_read;
    wire        is_queued;
    wire        is_auto;

    assign has_addr  = (cmd == `SFCFE_CMD_RD) | (cmd == `SFCFE_CMD_WR) |
                       (cmd == `SFCFE_CMD_ERASE) | (cmd == `SFCFE_CMD_VALID) |
                       (cmd == `SFCFE_CMD_CFG_WR) | (cmd == `SFCFE_CMD_CFG_RD);
    assign is_read   = (cmd == `SFCFE_CMD_RD) | (cmd == `SFCFE_CMD_RD_AUTO) |
                       (cmd == `SFCFE_CMD_CFG_RD);
    assign is_queued = (cmd == `SFCFE_CMD_WR) | (cmd == `SFCFE_CMD_WR_AUTO) |
                       (cmd == `SFCFE_CMD_ERASE) | (cmd == `SFCFE_CMD_VALID) |
                       (cmd == `SFCFE_CMD_CFG_WR) |
                       (cmd == `SFCFE_CMD_SPECIAL);
    assign is_auto   = (cmd == `SFCFE_CMD_RD_AUTO) |
                       (cmd == `SFCFE_CMD_WR_AUTO);

////////////////////////////////////////////////////////////////////////////
// Status assembly
    reg  cmd_err;
    reg  inv_err;
    reg  cmd_snap;
    reg  inv_snap;
    reg  busy_last;
    reg  frame_err_last;
    reg  rd_err_last;
    wire busy_now;
    reg  [7:0]  next_qs;
    reg  [15:0] next_sw;

    assign busy_now = i_read_busy | i_write_busy | i_erase_busy | o_req_valid;

    always @* begin
        next_qs = `SFCFE_QS_RESET;
        next_qs[`SFCFE_QS_UNUSED] = 1'b0;
        next_qs[`SFCFE_QS_FRAME]  = frame_err_last;
        next_qs[`SFCFE_QS_WBUSY]  = i_write_busy;
        next_qs[`SFCFE_QS_EBUSY]  = i_erase_busy;
        next_qs[`SFCFE_QS_DBUSY]  = busy_now | busy_last;
        next_qs[`SFCFE_QS_INVAL]  = inv_snap;
        next_qs[`SFCFE_QS_RDERR]  = rd_err_last;
        next_qs[`SFCFE_QS_CMDERR] = cmd_snap;
        next_sw = `SFCFE_SW_RESET;
        next_sw[`SFCFE_SW_REV_LO+3:`SFCFE_SW_REV_LO] = SILICON_REVISION_FIELD;
        next_sw[`SFCFE_SW_RBUSY] = i_read_busy;
        next_sw[`SFCFE_SW_WBUSY] = i_write_busy;
        next_sw[`SFCFE_SW_EBUSY] = i_erase_busy;
        next_sw[`SFCFE_SW_WSUSP] = i_write_susp;
        next_sw[`SFCFE_SW_ESUSP] = i_erase_susp;
        next_sw[`SFCFE_SW_PUMP]  = i_pump_ready;
        next_sw[`SFCFE_SW_FRAME] = frame_err_last;
    end

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_fast_status_byte  <= `SFCFE_QS_RESET;
            o_device_state_word <= `SFCFE_SW_RESET;
        end else begin
            o_fast_status_byte  <= next_qs;
            o_device_state_word <= next_sw;
        end
    end

////////////////////////////////////////////////////////////////////////////
// Request queue toward the flash controller
    reg  exec;
    wire push;
    wire push_ready;
    wire drop;
    wire clr_err;

    assign push    = exec & is_queued;
    assign drop    = push & ~push_ready;
    assign clr_err = exec & (cmd == `SFCFE_CMD_SPECIAL) &
                     (data == `SFCFE_CLR_ERR);

    sfcfe_fifo #(
        .W     (`SFCFE_REQ_W),
        .DEPTH (`SFCFE_FIFO_DEPTH),
        .AW    (`SFCFE_FIFO_AW)
    ) u_req_fifo (
        .i_clk       (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (push),
        .o_in_ready  (push_ready),
        .i_in_data   ({cmd, (is_auto ? addr_ptr + 24'h000001 : addr), data}),
        .o_out_valid (o_req_valid),
        .i_out_ready (i_req_ready),
        .o_out_data  ({o_req_cmd, o_req_addr, o_req_data})
    );

    // A full queue refuses the command; flagged like a failed one
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cmd_err <= 1'b0;
            inv_err <= 1'b0;
        end else begin
            // Set wins over the clear
            cmd_err <= i_cmd_fail | drop | (cmd_err & ~clr_err);
            inv_err <= i_invalid_data | (inv_err & ~clr_err);
        end
    end

////////////////////////////////////////////////////////////////////////////
// Frame engine
    reg        active;
    reg [2:0]  bit_cnt;
    reg [2:0]  idx;
    reg [2:0]  in_len;
    reg        done;
    reg        seen_rise;
    reg [6:0]  in_sh;
    reg [15:0] out_sh;
    reg        load_pend;
    reg        rd_err_cur;
    wire [7:0] in_byte;
    wire [3:0] pos;
    wire [2:0] byte_len;

    assign in_byte  = {in_sh, si_p[2]};
    assign pos      = has_addr ? {1'b0, idx} : {1'b0, idx} + 4'h3;
    assign byte_len = sfcfe_in_len(in_byte);

    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            active         <= 1'b0;
            bit_cnt        <= 3'h0;
            idx            <= 3'h0;
            in_len         <= 3'h0;
            done           <= 1'b0;
            seen_rise      <= 1'b0;
            in_sh          <= 7'h00;
            out_sh         <= 16'h0000;
            load_pend      <= 1'b0;
            rd_err_cur     <= 1'b0;
            exec           <= 1'b0;
            cmd            <= 8'h00;
            addr           <= 24'h000000;
            data           <= 16'h0000;
            addr_ptr       <= 24'h000000;
            o_rd_addr      <= 24'h000000;
            o_rd_cfg       <= 1'b0;
            o_so           <= 1'b0;
            o_so_oe        <= 1'b0;
            cmd_snap       <= 1'b0;
            inv_snap       <= 1'b0;
            busy_last      <= 1'b0;
            frame_err_last <= 1'b0;
            rd_err_last    <= 1'b0;
        end else begin
            exec <= 1'b0;
            if (cs_fall) begin
                active     <= 1'b1;
                bit_cnt    <= 3'h0;
                idx        <= 3'h0;
                done       <= 1'b0;
                seen_rise  <= 1'b0;
                load_pend  <= 1'b0;
                rd_err_cur <= 1'b0;
                out_sh     <= {next_qs, 8'h00};
                o_so       <= next_qs[7];
                o_so_oe    <= 1'b1;
            end else if (cs_rise) begin
                active  <= 1'b0;
                o_so_oe <= 1'b0;
                o_so    <= 1'b0;
                // Short frame: started but inputs incomplete
                frame_err_last <= active & ~done &
                                  (seen_rise | (idx != 3'h0));
                rd_err_last    <= rd_err_cur;
                cmd_snap       <= cmd_err;
                inv_snap       <= inv_err;
                busy_last      <= busy_now;
            end else if (active) begin
                if (sck_rise) begin
                    seen_rise <= 1'b1;
                    if (!done) begin
                        in_sh   <= in_byte[6:0];
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            idx <= idx + 3'h1;
                            if (idx == 3'h0) begin
                                cmd    <= in_byte;
                                in_len <= byte_len;
                                // Unknown code: swallow the frame
                                if (byte_len == `SFCFE_LEN_NONE) begin
                                    done <= 1'b1;
                                end else if (byte_len ==
                                             `SFCFE_LEN_STATUS) begin
                                    done <= 1'b1;
                                    exec <= 1'b1;
                                end
                            end else begin
                                case (pos)
                                    4'h1: addr[23:16] <= in_byte;
                                    4'h2: addr[15:8]  <= in_byte;
                                    4'h3: addr[7:0]   <= in_byte;
                                    4'h4: data[15:8]  <= in_byte;
                                    4'h5: data[7:0]   <= in_byte;
                                    default: ;
                                endcase
                                if (idx + 3'h1 == in_len) begin
                                    done <= 1'b1;
                                    exec <= 1'b1;
                                end
                            end
                        end
                    end
                end
                if (sck_fall && seen_rise) begin
                    if (load_pend) begin
                        load_pend <= 1'b0;
                        if (cmd == `SFCFE_CMD_STATUS) begin
                            out_sh <= o_device_state_word;
                            o_so   <= o_device_state_word[15];
                        end else begin
                            out_sh     <= i_rd_data;
                            o_so       <= i_rd_data[15];
                            rd_err_cur <= ~i_rd_ok;
                        end
                    end else begin
                        // Zeros follow once the frame is spent
                        out_sh <= {out_sh[14:0], 1'b0};
                        o_so   <= out_sh[14];
                    end
                end
            end
            if (exec) begin
                if (is_read || cmd == `SFCFE_CMD_STATUS) begin
                    load_pend <= 1'b1;
                end
                if (cmd == `SFCFE_CMD_CFG_RD) begin
                    o_rd_addr <= addr;
                    o_rd_cfg  <= 1'b1;
                end else if (cmd == `SFCFE_CMD_RD) begin
                    o_rd_addr <= addr;
                    o_rd_cfg  <= 1'b0;
                    addr_ptr  <= addr;
                end else if (cmd == `SFCFE_CMD_RD_AUTO) begin
                    o_rd_addr <= addr_ptr + 24'h000001;
                    o_rd_cfg  <= 1'b0;
                    addr_ptr  <= addr_ptr + 24'h000001;
                end else if (cmd == `SFCFE_CMD_WR) begin
                    addr_ptr  <= addr;
                end else if (cmd == `SFCFE_CMD_WR_AUTO) begin
                    addr_ptr  <= addr_ptr + 24'h000001;
                end
            end
        end
    end
endmodule // sfcfe_front_end

`default_nettype wire

/* rtl/sfcfe_consts.vh */
`ifndef SFCFE_CONSTS_VH
`define SFCFE_CONSTS_VH

////////////////////////////////////////////////////////////////////////////
// Command codes
`define SFCFE_CMD_RD       8'h15
`define SFCFE_CMD_RD_AUTO  8'h16
`define SFCFE_CMD_WR       8'h17
`define SFCFE_CMD_WR_AUTO  8'h18
`define SFCFE_CMD_ERASE    8'h19
`define SFCFE_CMD_VALID    8'h1a
`define SFCFE_CMD_CFG_WR   8'h1d
`define SFCFE_CMD_CFG_RD   8'h1e
`define SFCFE_CMD_SPECIAL  8'h1f
`define SFCFE_CMD_STATUS   8'h22

////////////////////////////////////////////////////////////////////////////
// Input bytes per command, command byte and dummy byte included
`define SFCFE_LEN_RD       3'h5
`define SFCFE_LEN_RD_AUTO  3'h2
`define SFCFE_LEN_WR       3'h7
`define SFCFE_LEN_WR_AUTO  3'h4
`define SFCFE_LEN_SEG      3'h5
`define SFCFE_LEN_CFG_WR   3'h7
`define SFCFE_LEN_CFG_RD   3'h5
`define SFCFE_LEN_SPECIAL  3'h4
`define SFCFE_LEN_STATUS   3'h1
`define SFCFE_LEN_NONE     3'h0

// Special-function data that clears the sticky errors
`define SFCFE_CLR_ERR      16'h0040

////////////////////////////////////////////////////////////////////////////
// Fast status byte fields and reset value
`define SFCFE_QS_RESET     8'h00
`define SFCFE_QS_UNUSED    7
`define SFCFE_QS_FRAME     6
`define SFCFE_QS_WBUSY     5
`define SFCFE_QS_EBUSY     4
`define SFCFE_QS_DBUSY     3
`define SFCFE_QS_INVAL     2
`define SFCFE_QS_RDERR     1
`define SFCFE_QS_CMDERR    0

// Device state word field positions
`define SFCFE_SW_REV_LO    8
`define SFCFE_SW_RBUSY     6
`define SFCFE_SW_WBUSY     5
`define SFCFE_SW_EBUSY     4
`define SFCFE_SW_WSUSP     3
`define SFCFE_SW_ESUSP     2
`define SFCFE_SW_PUMP      1
`define SFCFE_SW_FRAME     0
`define SFCFE_SW_RESET     16'h0000

// Request queue shape
`define SFCFE_FIFO_DEPTH   16
`define SFCFE_FIFO_AW      4
`define SFCFE_REQ_W        48

`endif

/* rtl/sfcfe_fifo.v */
`timescale 1ns/1ps
`default_nettype none

module sfcfe_fifo #(
    parameter W     = 48,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire         i_clk,
    input  wire         i_rst_n,
    input  wire         i_in_valid,
    output wire         o_in_ready,
    input  wire [W-1:0] i_in_data,
    output wire         o_out_valid,
    input  wire         i_out_ready,
    output wire [W-1:0] o_out_data
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0]   count;
    wire push;
    wire pop;

    assign o_in_ready  = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != {(AW+1){1'b0}});
    assign o_out_data  = mem[rd_ptr];
    assign push = i_in_valid & o_in_ready;
    assign pop  = o_out_valid & i_out_ready;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end

    // Storage needs no reset; validity comes from count
    always @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
endmodule // sfcfe_fifo

`default_nettype wire

/* verification/sfcfe_front_end_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sfcfe_front_end_monitor #(
    parameter [3:0] SILICON_REVISION_FIELD = 4'h5
) (
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    input wire logic        i_cs_n,
    input wire logic        i_sck,
    input wire logic        o_so,
    input wire logic        o_so_oe,
    input wire logic        o_req_valid,
    input wire logic [7:0]  o_req_cmd,
    input wire logic [23:0] o_req_addr,
    input wire logic [15:0] o_req_data,
    input wire logic        i_req_ready,
    input wire logic        i_write_busy,
    input wire logic        i_erase_busy,
    input wire logic [7:0]  o_fast_status_byte,
    input wire logic [15:0] o_device_state_word
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////
    // Eight cycles covers the pin synchroniser with margin
    sequence s_cs_idle; i_cs_n [*8]; endsequence
    sequence s_cs_open; !i_cs_n [*8]; endsequence
    sequence s_sck_high; (i_sck && o_so_oe) [*8]; endsequence
    a_oe_release: assert property (s_cs_idle |-> !o_so_oe)
        else $error("so enable high while deselected");
    a_oe_frame: assert property (s_cs_open |-> o_so_oe)
        else $error("so enable low inside a frame");
    a_oe_stay: assert property (o_so_oe && !i_cs_n |=> o_so_oe)
        else $error("so enable dropped with chip select low");
    a_so_hold: assert property (s_sck_high |-> $stable(o_so))
        else $error("so changed while serial clock high");
    a_qs_unused: assert property (!o_fast_status_byte[7])
        else $error("unused status bit set");
    a_busy_live: assert property ($past(i_rst_n) |->
        o_fast_status_byte[5:4] == $past({i_write_busy, i_erase_busy}))
        else $error("busy bits do not follow inputs");
    a_word_fixed: assert property ($past(i_rst_n) |->
        o_device_state_word[15:7] == {4'h0, SILICON_REVISION_FIELD, 1'b0})
        else $error("status word fixed fields wrong");
    a_req_hold: assert property (o_req_valid && !i_req_ready |=>
        o_req_valid && $stable({o_req_cmd, o_req_addr, o_req_data}))
        else $error("queued request changed before taken");
endmodule // sfcfe_front_end_monitor
bind sfcfe_front_end sfcfe_front_end_monitor #(
    .SILICON_REVISION_FIELD(SILICON_REVISION_FIELD)
) i_mon (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
    .i_sck(i_sck), .o_so(o_so), .o_so_oe(o_so_oe),
    .o_req_valid(o_req_valid), .o_req_cmd(o_req_cmd),
    .o_req_addr(o_req_addr), .o_req_data(o_req_data),
    .i_req_ready(i_req_ready), .i_write_busy(i_write_busy),
    .i_erase_busy(i_erase_busy), .o_fast_status_byte(o_fast_status_byte),
    .o_device_state_word(o_device_state_word)
);
`default_nettype wire

/* verification/sfcfe_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfcfe_spi_host (
    input  wire logic i_ref_clk,
    input  wire logic i_so,
    output var  logic o_cs_n,
    output var  logic o_sck,
    output var  logic o_si
);
    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_si   = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // Half a 64 ns serial period
    task automatic half();
        repeat (8) @(posedge i_ref_clk);
    endtask
    // Clock stands at idle level between frames; whole bytes only
    task automatic xfer(input logic mode3, input int n,
                        input logic [55:0] tx, output logic [55:0] rx);
        int b;
        rx = 56'h0;
        @(posedge i_ref_clk);
        o_sck <= mode3;
        half();
        o_cs_n <= 1'b0;
        half();
        for (b = 0; b < 8 * n; b++) begin
            o_sck <= 1'b0;
            o_si  <= tx[55 - b];
            half();
            o_sck <= 1'b1;
            rx = {rx[54:0], i_so};
            half();
        end
        o_sck <= mode3;
        half();
        o_cs_n <= 1'b1;
        // Released line must not look like a held bit
        o_si <= ~o_si;
        half();
        half();
        @(negedge i_ref_clk);
    endtask
endmodule // sfcfe_spi_host
`default_nettype wire

/* verification/sfcfe_front_end_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module sfcfe_front_end_tb;
    // Arbitrary revision value
    localparam logic [3:0] REV = 4'h6;
    logic        clk = 0, rst_n = 0, rd_ok = 1, req_ready = 0, fail = 0;
    logic        rb = 0, wb = 0, eb = 0, ws = 0, es = 0, pr = 0, inval = 0;
    logic        so, so_oe, rd_cfg, req_valid;
    logic [7:0]  req_cmd, qs;
    logic [15:0] rd_data, req_data, sw;
    logic [23:0] rd_addr, req_addr;
    logic [55:0] rx;
    wire         cs_n, sck, si;
    int          err_total = 0, tests_run = 0, i;
    sfcfe_front_end #(.SILICON_REVISION_FIELD(REV)) i_dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sck(sck),
        .i_si(si), .o_so(so), .o_so_oe(so_oe), .o_rd_addr(rd_addr),
        .o_rd_cfg(rd_cfg), .i_rd_data(rd_data), .i_rd_ok(rd_ok),
        .o_req_valid(req_valid), .o_req_cmd(req_cmd),
        .o_req_addr(req_addr), .o_req_data(req_data),
        .i_req_ready(req_ready), .i_read_busy(rb), .i_write_busy(wb),
        .i_erase_busy(eb), .i_write_susp(ws), .i_erase_susp(es),
        .i_pump_ready(pr), .i_cmd_fail(fail), .i_invalid_data(inval),
        .o_fast_status_byte(qs), .o_device_state_word(sw));
    // Undriven output reads as a pulled-up line
    sfcfe_spi_host i_host (.i_ref_clk(clk), .i_so(so_oe ? so : 1'b1),
        .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] arr(input logic c,
                                        input logic [23:0] a);
        return a[15:0] ^ (c ? 16'h3c3c : 16'ha5c3);
    endfunction
    always @(posedge clk) rd_data <= arr(rd_cfg, rd_addr);
    task automatic fr(input logic m, input int n, input logic [55:0] t);
        i_host.xfer(m, n, t, rx);
    endtask
    task automatic st();
        fr(1'b0, 1, 56'h22_0000_0000_0000);
    endtask
    task automatic pop(input logic [7:0] c, input logic [23:0] a,
                       input logic [15:0] d);
        @(negedge clk);
        `CHK(req_valid, 1'b1)
        `CHK(req_cmd, c)
        if (c != 8'h1f)
            `CHK(req_addr, a)
        if (c != 8'h19 && c != 8'h1a)
            `CHK(req_data, d)
        @(posedge clk);
        req_ready <= 1'b1;
        @(posedge clk);
        req_ready <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_write();
        `CHK({qs, sw}, {8'h00, 4'h0, REV, 8'h00})
        fr(1'b0, 7, 56'h17_123456_abcd_ff);
        `CHK(rx[55:48], 8'h00)
        pop(8'h17, 24'h123456, 16'habcd);
    endtask
    task automatic t_short();
        fr(1'b0, 2, 56'h1712_0000_0000_00);
        `CHK(req_valid, 1'b0)
        st();
        `CHK(rx[6], 1'b1)
        fr(1'b0, 4, 56'h33_0102_03_000000);
        `CHK(req_valid, 1'b0)
        st();
        `CHK(rx[7:0], 8'h00)
    endtask
    task automatic t_status();
        @(posedge clk);
        {rb, wb, eb, ws, es, pr} <= 6'h3f;
        fr(1'b0, 5, 56'h22_ffff_ffff_ff00);
        `CHK(rx[31:0], {4'h0, REV, 8'h7e, 16'h0000})
        @(posedge clk);
        {rb, wb, eb, ws, es, pr} <= 6'h00;
    endtask
    task automatic t_read();
        fr(1'b1, 7, 56'h15_000010_ff_ffff);
        `CHK(rx[47:0], {32'h0, arr(1'b0, 24'h10)})
        `CHK(rd_addr, 24'h000010)
        fr(1'b1, 4, 56'h16_ff_ffff_000000);
        `CHK(rx[23:0], {8'h00, arr(1'b0, 24'h11)})
        `CHK({rd_cfg, rd_addr}, {1'b0, 24'h000011})
        fr(1'b0, 7, 56'h1d_00f004_2bc0_ff);
        pop(8'h1d, 24'h00f004, 16'h2bc0);
        fr(1'b1, 7, 56'h1e_00f004_ff_ffff);
        `CHK(rx[15:0], arr(1'b1, 24'h00f004))
        @(posedge clk);
        rd_ok <= 1'b0;
        fr(1'b0, 7, 56'h1e_00f006_ff_ffff);
        `CHK(rd_cfg, 1'b1)
        @(posedge clk);
        rd_ok <= 1'b1;
        st();
        `CHK(rx[1], 1'b1)
        st();
        `CHK(rx[1], 1'b0)
    endtask
    task automatic t_sticky();
        @(posedge clk);
        {fail, inval} <= 2'b11;
        @(posedge clk);
        {fail, inval} <= 2'b00;
        st();
        `CHK(rx[7:0], 8'h00)
        st();
        `CHK(rx[7:0], 8'h05)
        fr(1'b0, 4, 56'h1f_0040_ff_000000);
        `CHK(rx[31:24], 8'h05)
        pop(8'h1f, 24'h0, 16'h0040);
        st();
        `CHK(rx[7:0], 8'h08)
        st();
        `CHK(rx[7:0], 8'h00)
    endtask
    task automatic t_fill();
        fr(1'b0, 5, 56'h19_020000_ff_0000);
        fr(1'b0, 5, 56'h1a_030000_ff_0000);
        // Sixteen fit; the last write is refused
        for (i = 0; i < 15; i++)
            fr(1'b0, 4, {16'h1800, i[7:0], 8'hff, 24'h0});
        st();
        `CHK(rx[0], 1'b1)
        pop(8'h19, 24'h020000, 16'h0);
        pop(8'h1a, 24'h030000, 16'h0);
        for (i = 0; i < 14; i++)
            pop(8'h18, i[23:0] + 24'h12, {8'h0, i[7:0]});
        @(negedge clk);
        `CHK(req_valid, 1'b0)
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_write();
        t_short();
        t_status();
        t_read();
        t_sticky();
        t_fill();
        finish_test();
    end
    // Run needs about 19k cycles; four times that cuts a hang
    initial begin
        #300000;
        err_total++;
        finish_test();
    end
endmodule // sfcfe_front_end_tb
`default_nettype wire
